// ==== cdd_decoder.sv ====
// Instruction decoder, address counter and character RAM of the display
`timescale 1ns/1ps
`default_nettype none

module cdd_decoder
    import cdd_pkg::*;
#(
    parameter int BLINK_HALF = CDD_BLINK_HALF_CYC,
    parameter int CNT_W = CDD_BLINK_CNT_W
) (
    input wire logic clk_i,            // Clock, 200 MHz
    input wire logic rst_i,            // Async reset, high
    input wire logic req_valid_i,      // Host byte strobe, one cycle
    input wire logic register_select_i,// 1 data, 0 instruction
    input wire logic req_read_i,       // 1 read, 0 write
    input wire logic [7:0] req_data_i, // Write byte
    output logic rsp_valid_o,          // Read answer strobe
    output logic [7:0] rsp_data_o,     // Read answer byte
    input wire logic scan_line_i,      // Scan line, 0 or 1
    input wire logic [4:0] scan_col_i, // Visible column 0..19
    input wire logic [2:0] scan_row_i, // Pixel row 0..7
    output logic [7:0] scan_code_o,    // Character code shown
    output logic scan_user_o,          // Code is a user glyph
    output logic [4:0] scan_bits_o,    // User glyph row pixels
    output logic scan_cursor_o,        // Cursor row overlay
    output logic scan_full_o,          // Blink all-on overlay
    output logic scan_blank_o,         // Display blanked
    output logic [6:0] address_counter_o, // Address counter
    output logic glyph_mode_o,         // Counter targets glyph RAM
    output logic incr_o,               // Increment-select
    output logic shift_en_o,           // Shift-enable
    output logic disp_on_o,            // Display on
    output logic cursor_on_o,          // Cursor on
    output logic blink_on_o,           // Blink enable
    output logic [5:0] shift_offset_o  // Display shift offset
);

    // ==========================================================
    // State
    logic [6:0] ac_q;
    logic [6:0] ac_d;
    logic glyph_q;
    logic glyph_d;
    logic incr_q;
    logic incr_d;
    logic shen_q;
    logic shen_d;
    logic disp_q;
    logic disp_d;
    logic curs_q;
    logic curs_d;
    logic blink_q;
    logic blink_d;
    logic [5:0] off_q;
    logic [5:0] off_d;
    logic [7:0] char_q [CDD_CHAR_LOCS];
    logic [CNT_W-1:0] blink_cnt_q;
    logic phase_q;
    logic rsp_valid_q;
    logic [7:0] rsp_data_q;
    logic [7:0] scan_code_q;
    logic scan_user_q;
    logic [4:0] scan_bits_q;
    logic scan_cursor_q;
    logic scan_full_q;
    logic scan_blank_q;

    // ==========================================================
    // Request decode
    wire instr_wr = req_valid_i & ~register_select_i & ~req_read_i;
    wire instr_rd = req_valid_i & ~register_select_i & req_read_i;
    wire data_wr = req_valid_i & register_select_i & ~req_read_i;
    wire data_rd = req_valid_i & register_select_i & req_read_i;
    wire data_acc = data_wr | data_rd;

    cdd_cmd_type cmd;

    always_comb begin
        cmd = CDD_CMD_NONE;
        if (instr_wr) begin
            if (req_data_i[CDD_BIT_CSET]) begin
                cmd = CDD_CMD_CSET;
            end else if (req_data_i[CDD_BIT_GSET]) begin
                cmd = CDD_CMD_GSET;
            end else if (req_data_i[CDD_BIT_FUNC]) begin
                cmd = CDD_CMD_FUNC;
            end else if (req_data_i[CDD_BIT_SHIFT]) begin
                cmd = CDD_CMD_SHIFT;
            end else if (req_data_i[CDD_BIT_ONOFF]) begin
                cmd = CDD_CMD_ONOFF;
            end else if (req_data_i[CDD_BIT_ENTRY]) begin
                cmd = CDD_CMD_ENTRY;
            end else if (req_data_i[CDD_BIT_HOME]) begin
                cmd = CDD_CMD_HOME;
            end else if (req_data_i[CDD_BIT_CLEAR]) begin
                cmd = CDD_CMD_CLEAR;
            end
        end
    end

    // ==========================================================
    // Address counter stepping
    function automatic logic [6:0] cdd_step(input logic [6:0] ac, input logic up, input logic glyph);
        logic [6:0] r;
        logic [5:0] lo;
        r = ac;
        lo = ac[5:0];
        if (glyph) begin
            lo = up ? lo + 6'h01 : lo - 6'h01;
            r = {1'b0, lo};
        end else if (up) begin
            if (ac == CDD_LINE1_END) begin
                r = CDD_LINE2_BASE;
            end else if (ac == CDD_LINE2_END) begin
                r = CDD_HOME;
            end else begin
                r = ac + 7'h01;
            end
        end else begin
            if (ac == CDD_LINE2_BASE) begin
                r = CDD_LINE1_END;
            end else if (ac == CDD_HOME) begin
                r = CDD_LINE2_END;
            end else begin
                r = ac - 7'h01;
            end
        end
        return r;
    endfunction

    // Left shift shows the next address in the first column
    wire [5:0] off_left = (off_q == CDD_OFF_LAST) ? CDD_OFF_ZERO : off_q + 6'h01;
    wire [5:0] off_right = (off_q == CDD_OFF_ZERO) ? CDD_OFF_LAST : off_q - 6'h01;

    // ==========================================================
    // Character RAM addressing; unmapped addresses drop writes, read zero
    wire ac_col_ok = ac_q[5:0] < CDD_LINE_LEN;
    wire [6:0] ac_idx = ac_q[6] ? 7'(ac_q[5:0]) + 7'(CDD_LINE_LEN) : 7'(ac_q[5:0]);
    wire char_hit = ~glyph_q & ac_col_ok;
    wire char_wr = data_wr & char_hit;
    wire clear_all = (cmd == CDD_CMD_CLEAR);
    wire [7:0] char_rd = char_hit ? char_q[ac_idx] : CDD_ZERO_BYTE;

    // ==========================================================
    // Glyph RAM
    wire glyph_wr = data_wr & glyph_q;
    wire [4:0] glyph_rd;
    wire [4:0] glyph_scan;
    wire [7:0] scan_code;
    wire [5:0] scan_gaddr = {scan_code[2:0], scan_row_i};

    cdd_glyph_ram #(
        .DEPTH(CDD_GLYPH_LOCS),
        .AW(6),
        .W(CDD_GLYPH_W)
    ) u_glyph (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(glyph_wr),
        .waddr_i(ac_q[5:0]),
        .wdata_i(req_data_i[4:0]),
        .rdata_o(glyph_rd),
        .saddr_i(scan_gaddr),
        .sdata_o(glyph_scan)
    );

    // ==========================================================
    // Next state of counter and settings
    always_comb begin
        ac_d = ac_q;
        glyph_d = glyph_q;
        incr_d = incr_q;
        shen_d = shen_q;
        disp_d = disp_q;
        curs_d = curs_q;
        blink_d = blink_q;
        off_d = off_q;
        unique case (cmd)
            CDD_CMD_CLEAR: begin
                ac_d = CDD_HOME;
                glyph_d = 1'b0;
                off_d = CDD_OFF_ZERO;
                incr_d = 1'b1;
            end
            CDD_CMD_HOME: begin
                ac_d = CDD_HOME;
                glyph_d = 1'b0;
                off_d = CDD_OFF_ZERO;
            end
            CDD_CMD_ENTRY: begin
                incr_d = req_data_i[CDD_F_INCR];
                shen_d = req_data_i[CDD_F_SHEN];
            end
            CDD_CMD_ONOFF: begin
                disp_d = req_data_i[CDD_F_DISP];
                curs_d = req_data_i[CDD_F_CURS];
                blink_d = req_data_i[CDD_F_BLINK];
            end
            CDD_CMD_SHIFT: begin
                ac_d = cdd_step(ac_q, req_data_i[CDD_F_RL], 1'b0);
                glyph_d = 1'b0;
                if (req_data_i[CDD_F_SC]) begin
                    off_d = req_data_i[CDD_F_RL] ? off_right : off_left;
                end
            end
            CDD_CMD_FUNC: begin
                ac_d = ac_q;
            end
            CDD_CMD_GSET: begin
                ac_d = {1'b0, req_data_i[5:0]};
                glyph_d = 1'b1;
            end
            CDD_CMD_CSET: begin
                ac_d = req_data_i[6:0];
                glyph_d = 1'b0;
            end
            CDD_CMD_NONE: begin
                if (data_acc) begin
                    ac_d = cdd_step(ac_q, incr_q, glyph_q);
                end
                if (data_wr && !glyph_q && shen_q) begin
                    off_d = incr_q ? off_left : off_right;
                end
            end
        endcase
    end

    // ==========================================================
    // Setting registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ac_q <= CDD_HOME;
            glyph_q <= 1'b0;
            incr_q <= CDD_RST_INCR;
            shen_q <= CDD_RST_SHEN;
            disp_q <= CDD_RST_DISP;
            curs_q <= CDD_RST_CURS;
            blink_q <= CDD_RST_BLINK;
            off_q <= CDD_OFF_ZERO;
        end else begin
            ac_q <= ac_d;
            glyph_q <= glyph_d;
            incr_q <= incr_d;
            shen_q <= shen_d;
            disp_q <= disp_d;
            curs_q <= curs_d;
            blink_q <= blink_d;
            off_q <= off_d;
        end
    end

    // ==========================================================
    // Character RAM, one flop row per location
    // Clear rewrites all 80 entries in one cycle; costs a wide fan-out, saves a sequencer
    genvar g;
    generate
        for (g = 0; g < CDD_CHAR_LOCS; g++) begin : g_char
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    char_q[g] <= CDD_BLANK_CODE;
                end else if (clear_all) begin
                    char_q[g] <= CDD_BLANK_CODE;
                end else if (char_wr && (ac_idx == 7'(g))) begin
                    char_q[g] <= req_data_i;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read answers
    wire [7:0] rsp_data = instr_rd ? {CDD_BUSY_VALUE, ac_q}
                        : glyph_q ? {3'h0, glyph_rd} : char_rd;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= CDD_ZERO_BYTE;
        end else begin
            rsp_valid_q <= instr_rd | data_rd;
            if (instr_rd || data_rd) begin
                rsp_data_q <= rsp_data;
            end
        end
    end

    // ==========================================================
    // Blink divider: one-cycle enable at each half period
    wire blink_tick = (blink_cnt_q == CNT_W'(BLINK_HALF - 1));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (blink_tick) begin
            blink_cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + CNT_W'(1);
        end
    end

    // ==========================================================
    // Scan mapping: visible column plus offset, modulo line length
    wire [6:0] col_sum = 7'(scan_col_i) + 7'(off_q);
    wire [6:0] col_mod = (col_sum >= 7'(CDD_LINE_LEN)) ? col_sum - 7'(CDD_LINE_LEN) : col_sum;
    wire [6:0] scan_idx = scan_line_i ? col_mod + 7'(CDD_LINE_LEN) : col_mod;
    assign scan_code = char_q[scan_idx];
    wire scan_user = (scan_code[7:4] == CDD_USER_HI);
    // Cursor only exists while the counter targets character RAM
    wire at_cursor = ~glyph_q & (ac_q[6] == scan_line_i) & (ac_q[5:0] == col_mod[5:0]);
    wire cursor_px = disp_q & curs_q & at_cursor & (scan_row_i == CDD_CURSOR_ROW);
    wire full_px = disp_q & blink_q & at_cursor & phase_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_code_q <= CDD_BLANK_CODE;
            scan_user_q <= 1'b0;
            scan_bits_q <= '0;
            scan_cursor_q <= 1'b0;
            scan_full_q <= 1'b0;
            scan_blank_q <= 1'b1;
        end else begin
            scan_code_q <= scan_code;
            scan_user_q <= scan_user;
            scan_bits_q <= scan_user ? glyph_scan : 5'h00;
            scan_cursor_q <= cursor_px;
            scan_full_q <= full_px;
            scan_blank_q <= ~disp_q;
        end
    end

    // ==========================================================
    // Outputs
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_data_o = rsp_data_q;
    assign scan_code_o = scan_code_q;
    assign scan_user_o = scan_user_q;
    assign scan_bits_o = scan_bits_q;
    assign scan_cursor_o = scan_cursor_q;
    assign scan_full_o = scan_full_q;
    assign scan_blank_o = scan_blank_q;
    assign address_counter_o = ac_q;
    assign glyph_mode_o = glyph_q;
    assign incr_o = incr_q;
    assign shift_en_o = shen_q;
    assign disp_on_o = disp_q;
    assign cursor_on_o = curs_q;
    assign blink_on_o = blink_q;
    assign shift_offset_o = off_q;

endmodule

`default_nettype wire

// ==== cdd_decoder_assertions.sv ====
// Port-level assertions for the character display command decoder
`timescale 1ns/1ps
`default_nettype none
module cdd_decoder_assertions (
    input wire logic clk_i,              // Clock
    input wire logic rst_i,              // Reset
    input wire logic req_valid_i,        // Byte strobe
    input wire logic register_select_i,  // Data or instr
    input wire logic req_read_i,         // Read flag
    input wire logic [7:0] req_data_i,   // Byte
    input wire logic rsp_valid_o,        // Answer strobe
    input wire logic [7:0] rsp_data_o,   // Answer byte
    input wire logic [6:0] address_counter_o, // Counter
    input wire logic glyph_mode_o,       // Glyph target
    input wire logic incr_o,             // Increment
    input wire logic shift_en_o,         // Shift enable
    input wire logic disp_on_o,          // Display on
    input wire logic [5:0] shift_offset_o // Offset
);
    // ==========================================================
    // Decoded host strobes
    wire logic ir = req_valid_i && !register_select_i && req_read_i;
    wire logic iw = req_valid_i && !register_select_i && !req_read_i;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_ans;
        1'b1 |=> rsp_valid_o == $past(req_valid_i && req_read_i);
    endproperty
    a_ans: assert property (p_ans) else $error("answer strobe wrong");
    property p_acrd;
        ir |=> rsp_data_o == {1'b0, $past(address_counter_o)} && $stable(address_counter_o);
    endproperty
    a_acrd: assert property (p_acrd) else $error("counter read wrong");
    property p_clear;
        iw && req_data_i == 8'h01 |=> address_counter_o == 7'h00 && shift_offset_o == 6'h00 && incr_o;
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong");
    property p_home;
        iw && req_data_i[7:1] == 7'h01 |=> address_counter_o == 7'h00 && shift_offset_o == 6'h00 && $stable(incr_o);
    endproperty
    a_home: assert property (p_home) else $error("home wrong");
    property p_entry;
        iw && req_data_i[7:2] == 6'h01 |=> incr_o == $past(req_data_i[1]) && shift_en_o == $past(req_data_i[0])
            && $stable(address_counter_o);
    endproperty
    a_entry: assert property (p_entry) else $error("entry mode wrong");
    property p_onoff;
        iw && req_data_i[7:3] == 5'h01 |=> disp_on_o == $past(req_data_i[2]) && $stable(address_counter_o)
            && $stable(shift_offset_o);
    endproperty
    a_onoff: assert property (p_onoff) else $error("on off wrong");
    property p_cshift;
        iw && req_data_i[7:4] == 4'h1 |=> !glyph_mode_o && address_counter_o != $past(address_counter_o)
            && ($past(req_data_i[3]) || $stable(shift_offset_o));
    endproperty
    a_cshift: assert property (p_cshift) else $error("cursor shift wrong");
    property p_cset;
        iw && req_data_i[7] |=> !glyph_mode_o && address_counter_o == $past(req_data_i[6:0]);
    endproperty
    a_cset: assert property (p_cset) else $error("char address set wrong");
    property p_gset;
        iw && req_data_i[7:6] == 2'b01 |=> glyph_mode_o && address_counter_o == {1'b0, $past(req_data_i[5:0])};
    endproperty
    a_gset: assert property (p_gset) else $error("glyph address set wrong");
    property p_noshift;
        req_valid_i && register_select_i && (req_read_i || glyph_mode_o) |=> $stable(shift_offset_o);
    endproperty
    a_noshift: assert property (p_noshift) else $error("unexpected shift");
endmodule
`default_nettype wire

// ==== cdd_glyph_ram.sv ====
// User glyph RAM: 64 entries of 5 bits, one write and two read ports
`timescale 1ns/1ps
`default_nettype none

module cdd_glyph_ram #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int W = 5
) (
    input wire logic clk_i,            // Clock
    input wire logic rst_i,            // Async reset, high
    input wire logic wr_i,             // Write strobe
    input wire logic [AW-1:0] waddr_i, // Write/read address
    input wire logic [W-1:0] wdata_i,  // Write data
    output logic [W-1:0] rdata_o,      // Read data at waddr_i
    input wire logic [AW-1:0] saddr_i, // Scan address
    output logic [W-1:0] sdata_o       // Scan data
);

    // ==========================================================
    // Storage
    logic [W-1:0] mem_q [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    mem_q[g] <= '0;
                end else if (wr_i && (waddr_i == AW'(g))) begin
                    mem_q[g] <= wdata_i;
                end
            end
        end
    endgenerate

    assign rdata_o = mem_q[waddr_i];
    assign sdata_o = mem_q[saddr_i];

endmodule

`default_nettype wire

// ==== cdd_host_model.sv ====
// Host processor model issuing instruction and data bytes
`timescale 1ns/1ps
`default_nettype none
module cdd_host_model (
    input wire logic clk_i,          // Clock
    output logic req_valid_o,        // Byte strobe
    output logic register_select_o,  // 1 data
    output logic req_read_o,         // 1 read
    output logic [7:0] req_data_o    // Byte
);
    initial begin
        req_valid_o = 1'b0;
        register_select_o = 1'b0;
        req_read_o = 1'b0;
        req_data_o = 8'h00;
    end
    // ==========================================================
    // One byte per call, strobe held one cycle
    task automatic send(input logic rs, input logic rd, input logic [7:0] d);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        register_select_o <= rs;
        req_read_o <= rd;
        req_data_o <= d;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        register_select_o <= ~rs;
        req_read_o <= ~rd;
        // Idle lines show the inverse
        req_data_o <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== cdd_pkg.sv ====
// Constants and types shared by the character display command decoder
package cdd_pkg;

    // ==========================================================
    // Address counter layout
    localparam logic [6:0] CDD_HOME = 7'h00;
    localparam logic [6:0] CDD_LINE1_END = 7'h27;
    localparam logic [6:0] CDD_LINE2_BASE = 7'h40;
    localparam logic [6:0] CDD_LINE2_END = 7'h67;
    localparam logic [5:0] CDD_LINE_LEN = 6'h28;
    localparam logic [5:0] CDD_OFF_LAST = 6'h27;
    localparam logic [5:0] CDD_OFF_ZERO = 6'h00;
    localparam int CDD_CHAR_LOCS = 80;
    localparam int CDD_GLYPH_LOCS = 64;
    localparam int CDD_GLYPH_W = 5;

    // ==========================================================
    // Data values
    localparam logic [7:0] CDD_BLANK_CODE = 8'h20;
    localparam logic [7:0] CDD_ZERO_BYTE = 8'h00;
    localparam logic [3:0] CDD_USER_HI = 4'h0;
    localparam logic [2:0] CDD_CURSOR_ROW = 3'h7;
    localparam logic CDD_BUSY_VALUE = 1'b0;

    // ==========================================================
    // Instruction byte: opcode bit, by most significant set bit
    localparam int CDD_BIT_CLEAR = 0;
    localparam int CDD_BIT_HOME = 1;
    localparam int CDD_BIT_ENTRY = 2;
    localparam int CDD_BIT_ONOFF = 3;
    localparam int CDD_BIT_SHIFT = 4;
    localparam int CDD_BIT_FUNC = 5;
    localparam int CDD_BIT_GSET = 6;
    localparam int CDD_BIT_CSET = 7;

    // Field positions
    localparam int CDD_F_INCR = 1;
    localparam int CDD_F_SHEN = 0;
    localparam int CDD_F_DISP = 2;
    localparam int CDD_F_CURS = 1;
    localparam int CDD_F_BLINK = 0;
    localparam int CDD_F_SC = 3;
    localparam int CDD_F_RL = 2;

    // ==========================================================
    // Reset values of the settings
    localparam logic CDD_RST_INCR = 1'b1;
    localparam logic CDD_RST_SHEN = 1'b0;
    localparam logic CDD_RST_DISP = 1'b0;
    localparam logic CDD_RST_CURS = 1'b0;
    localparam logic CDD_RST_BLINK = 1'b0;

    // ==========================================================
    // Timing
    localparam int CDD_CLK_MHZ = 200;
    localparam int CDD_BLINK_HALF_MS = 500;
    localparam int CDD_BLINK_HALF_CYC = CDD_BLINK_HALF_MS * 1000 * CDD_CLK_MHZ;
    localparam int CDD_BLINK_CNT_W = 27;

    // ==========================================================
    // Decoded command
    typedef enum logic [3:0] {
        CDD_CMD_NONE = 4'b0000,
        CDD_CMD_CLEAR = 4'b0001,
        CDD_CMD_HOME = 4'b0010,
        CDD_CMD_ENTRY = 4'b0011,
        CDD_CMD_ONOFF = 4'b0100,
        CDD_CMD_SHIFT = 4'b0101,
        CDD_CMD_FUNC = 4'b0110,
        CDD_CMD_GSET = 4'b0111,
        CDD_CMD_CSET = 4'b1000
    } cdd_cmd_type;

endpackage

// ==== cdd_testbench.sv ====
// Self-checking bench for the character display command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cdd_pkg::*;
    localparam int HALF = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i, register_select_i, req_read_i, rsp_valid_o, scan_user_o, scan_cursor_o, scan_full_o;
    logic scan_blank_o, glyph_mode_o, incr_o, shift_en_o, disp_on_o, cursor_on_o, blink_on_o;
    logic scan_line_i = 1'b0;
    logic [4:0] scan_col_i = 5'h00;
    logic [2:0] scan_row_i = 3'h0;
    logic [7:0] req_data_i, rsp_data_o, scan_code_o;
    logic [4:0] scan_bits_o;
    logic [6:0] address_counter_o;
    logic [5:0] shift_offset_o;
    logic [6:0] m_ac = 7'h00;
    logic m_gm = 1'b0, m_inc = 1'b1, m_sh = 1'b0, m_d = 1'b0, m_c = 1'b0, m_b = 1'b0;
    logic [5:0] m_off = 6'h00;
    logic [7:0] m_cr [128];
    logic [4:0] m_gr [64];
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [9:0] seq [$] = {10'h100, 10'h0a7, 10'h25a, 10'h0e7, 10'h2c3, 10'h004, 10'h0c0, 10'h300, 10'h080,
        10'h300, 10'h07f, 10'h006, 10'h2ff, 10'h004, 10'h040, 10'h300, 10'h300, 10'h007, 10'h090, 10'h241,
        10'h300, 10'h050, 10'h2aa, 10'h005, 10'h090, 10'h242, 10'h242, 10'h010, 10'h017, 10'h01a, 10'h01d,
        10'h045, 10'h014, 10'h03f, 10'h003, 10'h00f, 10'h001, 10'h0e7, 10'h23c, 10'h058, 10'h211, 10'h20a,
        10'h21f, 10'h204, 10'h215, 10'h200, 10'h21b, 10'h20e, 10'h080, 10'h20b, 10'h00e, 10'h003, 10'h300};
    always #2.5 clk_i = ~clk_i;
    cdd_host_model host (.clk_i, .req_valid_o(req_valid_i), .register_select_o(register_select_i),
        .req_read_o(req_read_i), .req_data_o(req_data_i));
    cdd_decoder #(.BLINK_HALF(HALF)) dut (.clk_i, .rst_i, .req_valid_i, .register_select_i, .req_read_i,
        .req_data_i, .rsp_valid_o, .rsp_data_o, .scan_line_i, .scan_col_i, .scan_row_i, .scan_code_o,
        .scan_user_o, .scan_bits_o, .scan_cursor_o, .scan_full_o, .scan_blank_o, .address_counter_o,
        .glyph_mode_o, .incr_o, .shift_en_o, .disp_on_o, .cursor_on_o, .blink_on_o, .shift_offset_o);
    // ==========================================================
    // Expectation helpers
    function automatic logic [6:0] f_step(input logic [6:0] a, input logic g, input logic up);
        if (g) return {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
        if (up) return a == CDD_LINE1_END ? CDD_LINE2_BASE : (a == CDD_LINE2_END ? CDD_HOME : a + 7'h01);
        return a == CDD_LINE2_BASE ? CDD_LINE1_END : (a == CDD_HOME ? CDD_LINE2_END : a - 7'h01);
    endfunction
    function automatic logic [5:0] f_off(input logic [5:0] o, input logic left);
        if (left) return o == CDD_OFF_LAST ? CDD_OFF_ZERO : o + 6'h01;
        return o == CDD_OFF_ZERO ? CDD_OFF_LAST : o - 6'h01;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_state;
        check({address_counter_o, glyph_mode_o, incr_o, shift_en_o, disp_on_o, cursor_on_o, blink_on_o,
            shift_offset_o}, {m_ac, m_gm, m_inc, m_sh, m_d, m_c, m_b, m_off});
    endtask
    task automatic decode(input logic [7:0] d);
        if (d[7]) {m_gm, m_ac} = {1'b0, d[6:0]};
        else if (d[6]) {m_gm, m_ac} = {2'b10, d[5:0]};
        else if (d[5]) begin
        end else if (d[4]) begin
            if (d[3]) m_off = f_off(m_off, !d[2]);
            {m_gm, m_ac} = {1'b0, f_step(m_ac, 1'b0, d[2])};
        end else if (d[3]) {m_d, m_c, m_b} = d[2:0];
        else if (d[2]) {m_inc, m_sh} = d[1:0];
        else if (d[1]) {m_gm, m_ac, m_off} = 14'h0000;
        else if (d[0]) begin
            {m_gm, m_ac, m_off, m_inc} = 15'h0001;
            foreach (m_cr[i]) m_cr[i] = CDD_BLANK_CODE;
        end
    endtask
    task automatic op(input logic r, input logic w, input logic [7:0] d);
        logic [7:0] e;
        e = 8'h00;
        host.send(r, w, d);
        if (!r && w) e = {1'b0, m_ac};
        else if (r && m_gm && w) e = {3'h0, m_gr[m_ac[5:0]]};
        else if (r && m_gm) m_gr[m_ac[5:0]] = d[4:0];
        else if (r && w && m_ac[5:0] < CDD_LINE_LEN) e = m_cr[m_ac];
        else if (r && !w && m_ac[5:0] < CDD_LINE_LEN) m_cr[m_ac] = d;
        if (r && !w && !m_gm && m_sh) m_off = f_off(m_off, m_inc);
        if (r) m_ac = f_step(m_ac, m_gm, m_inc);
        else if (!w) decode(d);
        #1;
        check(rsp_valid_o, w);
        if (w) check(rsp_data_o, e);
        chk_state();
    endtask
    task automatic scan(input logic ln, input logic [4:0] col, input logic [2:0] row);
        logic [6:0] a;
        logic [7:0] c;
        logic u;
        @(posedge clk_i);
        scan_line_i <= ln;
        scan_col_i <= col;
        scan_row_i <= row;
        a = {ln, (6'(col) + m_off) % CDD_LINE_LEN};
        c = m_cr[a];
        u = c[7:4] == CDD_USER_HI;
        @(posedge clk_i);
        #1;
        check({scan_code_o, scan_user_o, scan_bits_o, scan_cursor_o, scan_blank_o}, {c, u,
            u ? m_gr[{c[2:0], row}] : 5'h00, m_d && m_c && !m_gm && a == m_ac && row == CDD_CURSOR_ROW,
            !m_d});
    endtask
    task automatic blink(input int exp);
        int n;
        n = 0;
        repeat (4 * HALF) begin
            @(posedge clk_i);
            #1;
            if (scan_full_o === 1'b1) n++;
        end
        check(n, exp);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] d;
        foreach (m_cr[i]) m_cr[i] = CDD_BLANK_CODE;
        foreach (m_gr[i]) m_gr[i] = 5'h00;
        void'($urandom(32'h4e28c4fb));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_state();
        foreach (seq[i]) op(seq[i][9], seq[i][8], seq[i][7:0]);
        $display("Test directed finished");
        for (int r = 0; r < 8; r++) scan(1'b0, 5'h00, 3'(r));
        scan(1'b0, 5'h01, 3'h7);
        scan(1'b0, 5'h01, 3'h6);
        op(1'b0, 1'b0, 8'h0f);
        scan(1'b0, 5'h01, 3'h0);
        blink(2 * HALF);
        op(1'b0, 1'b0, 8'h0e);
        blink(0);
        for (int i = 0; i < 8; i++) begin
            op(1'b0, 1'b0, 8'h08 | 8'(i));
            scan(1'b0, 5'h01, 3'h7);
        end
        op(1'b0, 1'b0, 8'h1c);
        scan(1'b1, 5'h00, 3'h0);
        $display("Test scan finished");
        repeat (400) begin
            d = 8'($urandom);
            // Keep char addresses on the two lines
            if (d[7]) d[5:0] = 6'($urandom % 40);
            if (d[7:4] == 4'h1 && m_gm) d = 8'h02;
            op(1'($urandom), $urandom % 4 == 0, d);
            scan(1'($urandom), 5'($urandom % 20), 3'($urandom));
        end
        $display("Test random finished");
        print_verdict();
    end
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
endmodule
bind cdd_decoder cdd_decoder_assertions chk (.clk_i, .rst_i, .req_valid_i, .register_select_i, .req_read_i,
    .req_data_i, .rsp_valid_o, .rsp_data_o, .address_counter_o, .glyph_mode_o, .incr_o, .shift_en_o,
    .disp_on_o, .shift_offset_o);
`default_nettype wire
